//--- dv/sbrq_checker.sv
`timescale 1ns/100ps
module sbrq_checker (
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire logic                 bclkP,
    input wire logic                 busReset_b,
    input wire logic                 addrDevOe,
    input wire sbrq_pkg::sbrq_addr_t addrLines_b,
    input wire sbrq_pkg::sbrq_req_t  reqType_b,
    input wire logic                 addrValidStrobe_b,
    input wire logic [1:0]           addrSrcStrobes_b,
    input wire sbrq_pkg::sbrq_par_t  addrParity_b
);
    logic hiOdd;
    logic loOdd;
    assign hiOdd = ^(~addrLines_b[35:24]);
    assign loOdd = ^(~{addrLines_b[23:3], reqType_b});
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_avs_len;
        $fell(addrValidStrobe_b) |-> (!addrValidStrobe_b)[*8]
            ##1 (!addrValidStrobe_b)[*8] ##1 addrValidStrobe_b;
    endproperty
    a_avs_len: assert property (p_avs_len)
        else $error("address strobe length wrong");
    property p_strobes;
        $fell(addrValidStrobe_b) |-> (addrSrcStrobes_b == 2'h3)[*4]
            ##1 (addrSrcStrobes_b == 2'h0)[*8] ##1 (addrSrcStrobes_b == 2'h3);
    endproperty
    a_strobes: assert property (p_strobes)
        else $error("source strobe edges misplaced");
    property p_parity;
        $fell(addrValidStrobe_b) |-> addrParity_b == {~loOdd, ~hiOdd}
            ##8 addrParity_b == {~hiOdd, ~loOdd};
    endproperty
    a_parity: assert property (p_parity)
        else $error("address parity wrong");
    property p_release;
        $fell(addrValidStrobe_b) |-> ##16 (addrValidStrobe_b && !addrDevOe
            && reqType_b == 5'h1f && addrParity_b == 2'h3);
    endproperty
    a_release: assert property (p_release)
        else $error("lines not idle high after request");
    property p_oe;
        $fell(addrValidStrobe_b) |-> addrDevOe;
    endproperty
    a_oe: assert property (p_oe)
        else $error("address not driven with strobe");
    property p_addr_hold;
        $fell(addrValidStrobe_b) |-> ##1 $stable(addrLines_b)[*7]
            ##1 $stable(reqType_b)[*8];
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("subphase lines not held");
    property p_reset_quiet;
        !busReset_b |-> addrValidStrobe_b && !addrDevOe;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("request during bus reset");
    property p_bclk;
        $fell(addrValidStrobe_b) |-> bclkP;
    endproperty
    a_bclk: assert property (p_bclk)
        else $error("request not aligned to bus clock");
endmodule : sbrq_checker

//--- dv/system_bus_request_phase_test.sv
`timescale 1ns/100ps
module system_bus_request_phase_test;
    logic                 clk;
    logic                 rst_b;
    logic                 reqValid;
    logic                 reqReady;
    sbrq_pkg::sbrq_addr_t reqAddr;
    sbrq_pkg::sbrq_addr_t reqAttr;
    sbrq_pkg::sbrq_req_t  reqType;
    logic                 realMode;
    sbrq_pkg::sbrq_addr_t lookupAddr;
    logic                 cfgValid;
    sbrq_pkg::sbrq_cfg_t  cfgStraps;
    logic                 busy;
    logic                 resetReq;
    sbrq_pkg::sbrq_cfg_t  strapValue;
    logic                 bit20MaskReq;
    logic                 rxValid;
    sbrq_pkg::sbrq_addr_t rxAddr;
    sbrq_pkg::sbrq_addr_t rxAttr;
    sbrq_pkg::sbrq_req_t  rxType;
    logic                 rxParityErr;
    int                   errors = 0;
    int                   checked = 0;
    int                   cycles = 0;
    sbrq_pkg::sbrq_addr_t a;

    sbrq_bus_if bus ();
    sbrq_cpu_end u_sbrq_cpu_end (.clk(clk), .rst_b(rst_b), .bus(bus),
        .reqValid(reqValid), .reqReady(reqReady), .reqAddr(reqAddr),
        .reqAttr(reqAttr), .reqType(reqType), .realMode(realMode),
        .lookupAddr(lookupAddr), .cfgValid(cfgValid),
        .cfgStraps(cfgStraps), .busy(busy));
    sbrq_chipset_end u_sbrq_chipset_end (.clk(clk), .rst_b(rst_b),
        .bus(bus), .resetReq(resetReq), .strapValue(strapValue),
        .bit20MaskReq(bit20MaskReq), .rxValid(rxValid), .rxAddr(rxAddr),
        .rxAttr(rxAttr), .rxType(rxType), .rxParityErr(rxParityErr));
    sbrq_checker u_sbrq_checker (.clk(clk), .rst_b(rst_b),
        .bclkP(bus.bclkP), .busReset_b(bus.busReset_b),
        .addrDevOe(bus.addrDevOe), .addrLines_b(bus.addrLines_b),
        .reqType_b(bus.reqType_b),
        .addrValidStrobe_b(bus.addrValidStrobe_b),
        .addrSrcStrobes_b(bus.addrSrcStrobes_b),
        .addrParity_b(bus.addrParity_b));

    always #2.5 clk = ~clk;

    task automatic give_verdict;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            give_verdict();
        end
    end

    task automatic chk_addr(input sbrq_pkg::sbrq_addr_t got, exp,
                            input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s mismatch", $time, what);
        end
    endtask : chk_addr

    task automatic chk_small(input logic [7:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s mismatch", $time, what);
        end
    endtask : chk_small

    // expected wire parity, sub2 swaps the two covered groups
    function automatic logic [7:0] wire_par(input sbrq_pkg::sbrq_addr_t v,
                                            input sbrq_pkg::sbrq_req_t t,
                                            input logic sub2);
        logic hi;
        logic lo;
        hi = ^v[35:24];
        lo = ^{v[23:3], t};
        return {6'h0, sub2 ? ~{hi, lo} : ~{lo, hi}};
    endfunction : wire_par

    task automatic send(input sbrq_pkg::sbrq_addr_t ad, at,
                        input sbrq_pkg::sbrq_req_t t,
                        input sbrq_pkg::sbrq_addr_t expA);
        reqAddr = ad;
        reqAttr = at;
        reqType = t;
        reqValid = 1'b1;
        while (reqReady !== 1'b1) @(negedge clk);
        @(negedge clk);
        reqValid = 1'b0;
        chk_small({7'h0, reqReady}, 8'h0, "ready while busy");
        chk_small({7'h0, busy}, 8'h1, "busy");
        while (bus.addrValidStrobe_b !== 1'b0) @(negedge clk);
        chk_addr(bus.addrLines_b, ~expA, "wire addr");
        chk_small({3'h0, bus.reqType_b}, {3'h0, ~t}, "wire type");
        chk_small({6'h0, bus.addrParity_b}, wire_par(expA, t, 1'b0),
                  "parity1");
        repeat (8) @(negedge clk);
        chk_addr(bus.addrLines_b, ~at, "wire attr");
        chk_small({6'h0, bus.addrParity_b}, wire_par(at, t, 1'b1),
                  "parity2");
        while (rxValid !== 1'b1) @(negedge clk);
        chk_addr(rxAddr, expA, "rx addr");
        chk_addr(rxAttr, at, "rx attr");
        chk_small({3'h0, rxType}, {3'h0, t}, "rx type");
        chk_small({7'h0, rxParityErr}, 8'h0, "parity flag");
        chk_addr(lookupAddr, expA, "lookup");
        while (busy !== 1'b0) @(negedge clk);
    endtask : send

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        reqValid = 1'b0;
        reqAddr = '0;
        reqAttr = '0;
        reqType = '0;
        realMode = 1'b0;
        resetReq = 1'b1;
        strapValue = 8'ha5;
        bit20MaskReq = 1'b0;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        chk_small({7'h0, cfgValid}, 8'h0, "cfg early");
        resetReq = 1'b0;
        while (cfgValid !== 1'b1) @(negedge clk);
        chk_small(cfgStraps, 8'ha5, "straps");
        $display("test straps done");
        for (int i = 0; i < 32; i++) begin
            a = 33'h1_3579_bdf1 * (i + 1);
            send(a, ~a, i[4:0], a);
        end
        send('1, '0, 5'h1f, '1);
        send('0, '1, 5'h00, '0);
        $display("test types done");
        a = 33'h0_0002_0080;
        bit20MaskReq = 1'b1;
        realMode = 1'b1;
        repeat (10) @(negedge clk);
        send(a, 33'h0_0000_0011, 5'h03, 33'h0_0000_0080);
        realMode = 1'b0;
        send(a, 33'h0_0000_0011, 5'h03, a);
        bit20MaskReq = 1'b0;
        realMode = 1'b1;
        repeat (10) @(negedge clk);
        send(a, 33'h0_0000_0011, 5'h03, a);
        $display("test mask done");
        give_verdict();
    end
endmodule : system_bus_request_phase_test

//--- rtl/sbrq_bus_if.sv
`timescale 1ns/100ps
interface sbrq_bus_if;
    logic                 bclkP;
    logic                 bclkN;
    logic                 busReset_b;
    logic                 bit20MaskIn_b;
    sbrq_pkg::sbrq_addr_t addrDevOut;
    logic                 addrDevOe;
    sbrq_pkg::sbrq_addr_t addrHostOut;
    logic                 addrHostOe;
    sbrq_pkg::sbrq_addr_t addrLines_b;
    sbrq_pkg::sbrq_req_t  reqType_b;
    logic                 addrValidStrobe_b;
    logic [1:0]           addrSrcStrobes_b;
    sbrq_pkg::sbrq_par_t  addrParity_b;

    // shared address wires, pulled high when nobody drives
    assign addrLines_b = addrDevOe ? addrDevOut :
                         (addrHostOe ? addrHostOut : '1);

    modport cpu (
        input  bclkP, bclkN, busReset_b, bit20MaskIn_b, addrLines_b,
        output addrDevOut, addrDevOe, reqType_b, addrValidStrobe_b,
        output addrSrcStrobes_b, addrParity_b
    );
    modport chipset (
        output bclkP, bclkN, busReset_b, bit20MaskIn_b,
        output addrHostOut, addrHostOe,
        input  addrLines_b, reqType_b, addrValidStrobe_b,
        input  addrSrcStrobes_b, addrParity_b
    );
endinterface : sbrq_bus_if

//--- rtl/sbrq_chipset_end.sv
`timescale 1ns/100ps
module sbrq_chipset_end (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    sbrq_bus_if.chipset               bus,
    input  wire logic                 resetReq,
    input  wire sbrq_pkg::sbrq_cfg_t  strapValue,
    input  wire logic                 bit20MaskReq,
    output logic                      rxValid,
    output sbrq_pkg::sbrq_addr_t      rxAddr,
    output sbrq_pkg::sbrq_addr_t      rxAttr,
    output sbrq_pkg::sbrq_req_t       rxType,
    output logic                      rxParityErr
);
    typedef enum logic [1:0] {RX_IDLE, RX_SUB1, RX_SUB2} sbrq_rx_t;
    localparam int PIN_W = 1 + 2 + sbrq_pkg::PAR_W + sbrq_pkg::REQ_W;

    sbrq_rx_t             state_reg,  state_next;
    sbrq_pkg::sbrq_cnt_t  div_reg,    div_next;
    logic                 bclk_reg,   bclk_next;
    logic                 rst_reg,    rst_next;
    logic                 mask_reg,   mask_next;
    sbrq_pkg::sbrq_cnt_t  hold_reg,   hold_next;
    logic [PIN_W-1:0]     pinMeta_reg, pinSync_reg, pinPrev_reg;
    sbrq_pkg::sbrq_addr_t adMeta_reg, adSync_reg;
    logic [1:0]           seen_reg,   seen_next;
    sbrq_pkg::sbrq_addr_t addr_reg,   addr_next;
    sbrq_pkg::sbrq_addr_t attr_reg,   attr_next;
    sbrq_pkg::sbrq_req_t  type_reg,   type_next;
    sbrq_pkg::sbrq_req_t  type2_reg,  type2_next;
    sbrq_pkg::sbrq_par_t  par1_reg,   par1_next;
    sbrq_pkg::sbrq_par_t  par2_reg,   par2_next;
    logic                 valid_reg,  valid_next;
    logic                 err_reg,    err_next;
    logic                 avsFall;
    logic [1:0]           stbFall;
    logic [1:0]           stbRise;
    logic [1:0]           seenNow;
    sbrq_pkg::sbrq_addr_t rxLines;
    sbrq_pkg::sbrq_req_t  rxReq;
    sbrq_pkg::sbrq_par_t  rxPar;

    // bus clock divider, reset, straps and bit-20 mask
    always_comb begin
        div_next  = div_reg + sbrq_pkg::sbrq_cnt_t'(1);
        bclk_next = bclk_reg;
        if (div_reg == sbrq_pkg::sbrq_cnt_t'(sbrq_pkg::SUB_CYC - 1)) begin
            div_next  = '0;
            bclk_next = ~bclk_reg; // RULE_16
        end
        rst_next  = resetReq;
        hold_next = hold_reg;
        if (rst_reg) begin
            hold_next = sbrq_pkg::sbrq_cnt_t'(sbrq_pkg::CFG_HOLD_CYC);
        end else if (hold_reg != '0) begin
            hold_next = hold_reg - sbrq_pkg::sbrq_cnt_t'(1);
        end
        mask_next = bit20MaskReq; // RULE_08
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div_reg  <= '0;
            bclk_reg <= 1'b0;
            rst_reg  <= 1'b1;
            hold_reg <= '0;
            mask_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            bclk_reg <= bclk_next;
            rst_reg  <= rst_next;
            hold_reg <= hold_next;
            mask_reg <= mask_next;
        end
    end

    assign bus.bclkP         = bclk_reg;
    assign bus.bclkN         = ~bclk_reg;
    assign bus.busReset_b    = ~rst_reg;
    assign bus.bit20MaskIn_b = ~mask_reg;
    assign bus.addrHostOe    = rst_reg || (hold_reg != '0);
    assign bus.addrHostOut   =
        ~{{(sbrq_pkg::ADDR_MSB - sbrq_pkg::CFG_MSB){1'b0}}, strapValue};

    // pin synchronisers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pinMeta_reg <= '1;
            pinSync_reg <= '1;
            pinPrev_reg <= '1;
            adMeta_reg  <= '1;
            adSync_reg  <= '1;
        end else begin
            pinMeta_reg <= {bus.addrValidStrobe_b, bus.addrSrcStrobes_b,
                            bus.addrParity_b, bus.reqType_b};
            pinSync_reg <= pinMeta_reg;
            pinPrev_reg <= pinSync_reg;
            adMeta_reg  <= bus.addrLines_b;
            adSync_reg  <= adMeta_reg;
        end
    end

    // receive: active-low wires inverted to logical values
    always_comb begin
        rxLines    = ~adSync_reg; // RULE_17
        rxReq      = ~pinSync_reg[sbrq_pkg::REQ_W-1:0];
        rxPar      = ~pinSync_reg[sbrq_pkg::REQ_W +: sbrq_pkg::PAR_W];
        avsFall    = ~pinSync_reg[PIN_W-1] & pinPrev_reg[PIN_W-1];
        stbFall    = ~pinSync_reg[PIN_W-2 -: 2] & pinPrev_reg[PIN_W-2 -: 2];
        stbRise    = pinSync_reg[PIN_W-2 -: 2] & ~pinPrev_reg[PIN_W-2 -: 2];
        state_next = state_reg;
        seen_next  = seen_reg;
        addr_next  = addr_reg;
        attr_next  = attr_reg;
        type_next  = type_reg;
        type2_next = type2_reg;
        par1_next  = par1_reg;
        par2_next  = par2_reg;
        valid_next = 1'b0;
        err_next   = err_reg;
        seenNow    = seen_reg;
        case (state_reg)
            RX_IDLE: begin
                if (avsFall) begin // RULE_10
                    state_next = RX_SUB1;
                    seen_next  = '0;
                end
            end
            RX_SUB1: begin
                seenNow = seen_reg | stbFall; // RULE_12
                if (stbFall[sbrq_pkg::STB_LO]) begin // RULE_13
                    addr_next[sbrq_pkg::STB_LO_MSB:sbrq_pkg::ADDR_LSB] =
                        rxLines[sbrq_pkg::STB_LO_MSB:sbrq_pkg::ADDR_LSB];
                    type_next = rxReq;
                    par1_next = rxPar;
                end
                if (stbFall[sbrq_pkg::STB_HI]) begin // RULE_13
                    addr_next[sbrq_pkg::ADDR_MSB:sbrq_pkg::STB_HI_LSB] =
                        rxLines[sbrq_pkg::ADDR_MSB:sbrq_pkg::STB_HI_LSB];
                end
                seen_next = seenNow;
                if (seenNow == 2'h3) begin
                    state_next = RX_SUB2;
                    seen_next  = '0;
                end
            end
            RX_SUB2: begin
                seenNow = seen_reg | stbRise; // RULE_12
                if (stbRise[sbrq_pkg::STB_LO]) begin // RULE_04
                    attr_next[sbrq_pkg::STB_LO_MSB:sbrq_pkg::ADDR_LSB] =
                        rxLines[sbrq_pkg::STB_LO_MSB:sbrq_pkg::ADDR_LSB];
                    type2_next = rxReq;
                    par2_next  = rxPar;
                end
                if (stbRise[sbrq_pkg::STB_HI]) begin // RULE_01
                    attr_next[sbrq_pkg::ADDR_MSB:sbrq_pkg::STB_HI_LSB] =
                        rxLines[sbrq_pkg::ADDR_MSB:sbrq_pkg::STB_HI_LSB];
                end
                seen_next = seenNow;
                if (seenNow == 2'h3) begin
                    state_next = RX_IDLE;
                    valid_next = 1'b1; // RULE_11
                    err_next   = // RULE_03 RULE_15
                        (sbrq_pkg::sbrqParity(addr_reg, type_reg, 1'b0)
                         != par1_reg) ||
                        (sbrq_pkg::sbrqParity(attr_next, type2_next, 1'b1)
                         != par2_next);
                end
            end
            default: state_next = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= RX_IDLE;
            seen_reg  <= '0;
            addr_reg  <= '0;
            attr_reg  <= '0;
            type_reg  <= '0;
            type2_reg <= '0;
            par1_reg  <= '0;
            par2_reg  <= '0;
            valid_reg <= 1'b0;
            err_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            seen_reg  <= seen_next;
            addr_reg  <= addr_next;
            attr_reg  <= attr_next;
            type_reg  <= type_next;
            type2_reg <= type2_next;
            par1_reg  <= par1_next;
            par2_reg  <= par2_next;
            valid_reg <= valid_next;
            err_reg   <= err_next;
        end
    end

    assign rxValid     = valid_reg;
    assign rxAddr      = addr_reg;
    assign rxAttr      = attr_reg;
    assign rxType      = type_reg;
    assign rxParityErr = err_reg;
endmodule : sbrq_chipset_end

//--- rtl/sbrq_cpu_end.sv
`timescale 1ns/100ps
// Overview of operation
// RULE_01: address first subphase, type info second
// RULE_02: address lines span bits 35 to 3
// RULE_03: two parity bits protect every request
// RULE_04: address lines travel with source strobes
// RULE_05: reset release samples address pins as configuration
// RULE_06: mask input forces address bit 20 low; the code forces it only while realMode is high
// RULE_07: masking gives one-megabyte wrap-around
// RULE_08: system asserts mask only in real mode; the chipset end drives it from bit20MaskReq alone, whatever the mode
// RULE_09: mask asynchronous, valid by target ready
// RULE_10: address-valid strobe marks new transaction
// RULE_11: agents start checking on address-valid strobe
// RULE_12: capture on both strobe edges
// RULE_13: low strobe bits 16..3, high 35..17
// RULE_14: parity driven with strobe, address, type
// RULE_15: parity high for even count of lows
// RULE_16: bus clock times outputs and inputs
// RULE_17: all these signals active low
module sbrq_cpu_end (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    sbrq_bus_if.cpu                   bus,
    input  wire logic                 reqValid,
    output logic                      reqReady,
    input  wire sbrq_pkg::sbrq_addr_t reqAddr,
    input  wire sbrq_pkg::sbrq_addr_t reqAttr,
    input  wire sbrq_pkg::sbrq_req_t  reqType,
    input  wire logic                 realMode,
    output sbrq_pkg::sbrq_addr_t      lookupAddr,
    output logic                      cfgValid,
    output sbrq_pkg::sbrq_cfg_t       cfgStraps,
    output logic                      busy
);
    typedef enum logic [1:0] {TX_IDLE, TX_SUB1, TX_SUB2} sbrq_tx_t;
    localparam int SYN_BCLK = 0;
    localparam int SYN_RST  = 1;
    localparam int SYN_MASK = 2;

    logic [2:0]           synMeta_reg;
    logic [2:0]           synSync_reg;
    logic [2:0]           synPrev_reg;
    sbrq_pkg::sbrq_addr_t adMeta_reg;
    sbrq_pkg::sbrq_addr_t adSync_reg;
    logic                 bclkRise;
    logic                 rstRise;
    logic                 inReset;
    logic                 maskOn;

    sbrq_tx_t             state_reg,   state_next;
    sbrq_pkg::sbrq_cnt_t  cnt_reg,     cnt_next;
    logic                 pend_reg,    pend_next;
    sbrq_pkg::sbrq_addr_t pAddr_reg,   pAddr_next;
    sbrq_pkg::sbrq_addr_t pAttr_reg,   pAttr_next;
    sbrq_pkg::sbrq_req_t  pType_reg,   pType_next;
    sbrq_pkg::sbrq_addr_t aOut_reg,    aOut_next;
    logic                 aOe_reg,     aOe_next;
    sbrq_pkg::sbrq_req_t  rOut_reg,    rOut_next;
    logic                 avs_reg,     avs_next;
    logic [1:0]           stb_reg,     stb_next;
    sbrq_pkg::sbrq_par_t  par_reg,     par_next;
    logic                 cfgV_reg,    cfgV_next;
    sbrq_pkg::sbrq_cfg_t  cfg_reg,     cfg_next;
    sbrq_pkg::sbrq_addr_t maskedAddr;

    // synchronisers for bus clock, reset, mask and address pins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            synMeta_reg <= 3'h7;
            synSync_reg <= 3'h7;
            synPrev_reg <= 3'h7;
            adMeta_reg  <= '1;
            adSync_reg  <= '1;
        end else begin
            synMeta_reg <= {bus.bit20MaskIn_b, bus.busReset_b, bus.bclkP};
            synSync_reg <= synMeta_reg;
            synPrev_reg <= synSync_reg;
            adMeta_reg  <= bus.addrLines_b;
            adSync_reg  <= adMeta_reg;
        end
    end

    always_comb begin
        bclkRise = synSync_reg[SYN_BCLK] & ~synPrev_reg[SYN_BCLK]; // RULE_16
        rstRise  = synSync_reg[SYN_RST] & ~synPrev_reg[SYN_RST];
        inReset  = ~synSync_reg[SYN_RST];
        maskOn   = ~synSync_reg[SYN_MASK] & realMode; // RULE_09
    end

    // bit 20 forced low while the mask is asserted and realMode is high, so addresses wrap at one megabyte
    always_comb begin
        maskedAddr = reqAddr;
        if (maskOn) begin
            maskedAddr[sbrq_pkg::BIT_TWENTY] = 1'b0; // RULE_06 RULE_07
        end
    end

    assign reqReady = (state_reg == TX_IDLE) && !pend_reg && cfgV_reg &&
                      !inReset;

    // request transmit sequencing
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg + sbrq_pkg::sbrq_cnt_t'(1);
        pend_next  = pend_reg;
        pAddr_next = pAddr_reg;
        pAttr_next = pAttr_reg;
        pType_next = pType_reg;
        aOut_next  = aOut_reg;
        aOe_next   = aOe_reg;
        rOut_next  = rOut_reg;
        avs_next   = avs_reg;
        stb_next   = stb_reg;
        par_next   = par_reg;
        cfgV_next  = cfgV_reg;
        cfg_next   = cfg_reg;
        if (rstRise) begin
            cfg_next  = // RULE_05
                ~adSync_reg[sbrq_pkg::CFG_MSB:sbrq_pkg::ADDR_LSB];
            cfgV_next = 1'b1;
        end
        if (reqValid && reqReady) begin
            pend_next  = 1'b1;
            pAddr_next = maskedAddr; // RULE_06
            pAttr_next = reqAttr;
            pType_next = reqType;
        end
        case (state_reg)
            TX_IDLE: begin
                if (bclkRise && pend_reg) begin
                    state_next = TX_SUB1;
                    cnt_next   = '0;
                    pend_next  = 1'b0;
                    aOut_next  = pAddr_reg; // RULE_01 RULE_02
                    rOut_next  = pType_reg;
                    aOe_next   = 1'b1;
                    avs_next   = 1'b1; // RULE_10
                    par_next   = sbrq_pkg::sbrqParity(pAddr_reg, pType_reg,
                                                      1'b0); // RULE_14
                end
            end
            TX_SUB1: begin
                if (cnt_reg ==
                    sbrq_pkg::sbrq_cnt_t'(sbrq_pkg::STB_OFS_CYC - 1)) begin
                    stb_next = 2'h3; // RULE_04 RULE_13
                end
                if (cnt_reg == sbrq_pkg::sbrq_cnt_t'(sbrq_pkg::SUB_CYC - 1))
                begin
                    state_next = TX_SUB2;
                    aOut_next  = pAttr_reg; // RULE_01
                    par_next   = sbrq_pkg::sbrqParity(pAttr_reg, rOut_reg,
                                                      1'b1); // RULE_03
                end
            end
            TX_SUB2: begin
                if (cnt_reg == sbrq_pkg::sbrq_cnt_t'(sbrq_pkg::SUB_CYC +
                                sbrq_pkg::STB_OFS_CYC - 1)) begin
                    stb_next = 2'h0; // RULE_12
                end
                if (cnt_reg == sbrq_pkg::sbrq_cnt_t'(sbrq_pkg::BCLK_CYC - 1))
                begin
                    state_next = TX_IDLE;
                    aOe_next   = 1'b0;
                    avs_next   = 1'b0;
                    rOut_next  = '0;
                    par_next   = '0;
                end
            end
            default: state_next = TX_IDLE;
        endcase
        if (inReset) begin
            state_next = TX_IDLE;
            pend_next  = 1'b0;
            aOe_next   = 1'b0;
            avs_next   = 1'b0;
            stb_next   = 2'h0;
            rOut_next  = '0;
            par_next   = '0;
            cfgV_next  = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= TX_IDLE;
            cnt_reg   <= '0;
            pend_reg  <= 1'b0;
            pAddr_reg <= '0;
            pAttr_reg <= '0;
            pType_reg <= '0;
            aOut_reg  <= '0;
            aOe_reg   <= 1'b0;
            rOut_reg  <= '0;
            avs_reg   <= 1'b0;
            stb_reg   <= 2'h0;
            par_reg   <= '0;
            cfgV_reg  <= 1'b0;
            cfg_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            pend_reg  <= pend_next;
            pAddr_reg <= pAddr_next;
            pAttr_reg <= pAttr_next;
            pType_reg <= pType_next;
            aOut_reg  <= aOut_next;
            aOe_reg   <= aOe_next;
            rOut_reg  <= rOut_next;
            avs_reg   <= avs_next;
            stb_reg   <= stb_next;
            par_reg   <= par_next;
            cfgV_reg  <= cfgV_next;
            cfg_reg   <= cfg_next;
        end
    end

    // wires carry inverted logical values; parity inverse gives even-low high
    assign bus.addrDevOut        = ~aOut_reg; // RULE_17
    assign bus.addrDevOe         = aOe_reg;
    assign bus.reqType_b         = ~rOut_reg;
    assign bus.addrValidStrobe_b = ~avs_reg;
    assign bus.addrSrcStrobes_b  = ~stb_reg;
    assign bus.addrParity_b      = ~par_reg; // RULE_15
    assign lookupAddr            = pAddr_reg;
    assign cfgValid              = cfgV_reg;
    assign cfgStraps             = cfg_reg;
    assign busy                  = (state_reg != TX_IDLE) || pend_reg;
endmodule : sbrq_cpu_end

//--- rtl/sbrq_pkg.sv
package sbrq_pkg;
    localparam int ADDR_MSB       = 35;
    localparam int ADDR_LSB       = 3;
    localparam int REQ_W          = 5;
    localparam int PAR_W          = 2;
    localparam int BIT_TWENTY     = 20;
    localparam int STB_LO_MSB     = 16;
    localparam int STB_HI_LSB     = 17;
    localparam int PAR_SPLIT      = 24;
    localparam int CFG_MSB        = 10;
    localparam int CLK_PERIOD_NS  = 5;
    localparam int BCLK_PERIOD_NS = 80;
    localparam int BCLK_CYC       = BCLK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SUB_CYC        = BCLK_CYC / 2;
    localparam int STB_OFS_CYC    = SUB_CYC / 2;
    localparam int CFG_HOLD_NS    = 40;
    localparam int CFG_HOLD_CYC   =
        (CFG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W          = 5;
    localparam int STB_LO         = 0;
    localparam int STB_HI         = 1;

    typedef logic [ADDR_MSB:ADDR_LSB] sbrq_addr_t;
    typedef logic [REQ_W-1:0]         sbrq_req_t;
    typedef logic [PAR_W-1:0]         sbrq_par_t;
    typedef logic [CFG_MSB:ADDR_LSB]  sbrq_cfg_t;
    typedef logic [CNT_W-1:0]         sbrq_cnt_t;

    // logical parity; wire value is the inverse (high for even lows)
    function automatic sbrq_par_t sbrqParity(
        input sbrq_addr_t addr,
        input sbrq_req_t  req,
        input logic       sub2
    );
        logic hiPar;
        logic loPar;
        hiPar = ^addr[ADDR_MSB:PAR_SPLIT];
        loPar = ^{addr[PAR_SPLIT-1:ADDR_LSB], req};
        sbrqParity = sub2 ? {hiPar, loPar} : {loPar, hiPar};
    endfunction : sbrqParity
endpackage : sbrq_pkg
